// ### rtl/igpd_top.sv
// ISA general-purpose pin decoder: key unlock, config registers, two pins
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Index port then data port; only in extended mode; 10H-15H hold pin registers.
// - Key value select is bit 5 of index 0CH, resets to 1.
// - Index 10H holds pin zero match address bits 7-0, reset zero.
// - Index 11H bits 2-0 hold address bits 10-8; bits 5-3 reserved.
// - Index 11H bits 7-6 pick how many low bits are ignored.
// - Pin one address lives at 12H and 13H bits 2-0, reset zero.
// - Index 13H bits 7-6 mask pin one compare the same way.
// - Index 14H bits 7-5 pick function; 000 tri-states the pin.
// - Output mode drives data line 0 onto pin on matching write.
// - Input mode puts pin level on data line 0 on matching read.
// - Bidirectional mode does both output and input behaviour.
// - Top mode bit makes the pin a decoded chip select.
// - Bit 4 sets chip select active level, 1 high.
// - Bits 3-2 qualify select by no strobe, write, read, or either strobe.
// - Bit 1 inverts bus-to-pin, bit 0 inverts pin-to-bus.
// - Index 15H configures pin one the same way, reset zero.
module igpd_top
	import igpd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [10:0] sa,
	input wire logic aen_n,
	input wire logic iow_n,
	input wire logic ior_n,
	input wire logic [7:0] sd_in,
	output logic [7:0] sd_out,
	output logic sd_oe,
	input wire logic key_addr_sel,
	input wire logic gp_pin_zero_in,
	output logic gp_pin_zero_out,
	output logic gp_pin_zero_oe,
	input wire logic gp_pin_one_in,
	output logic gp_pin_one_out,
	output logic gp_pin_one_oe
);
	// ----------------------------------------
	// Pin input synchronisers
	// ----------------------------------------
	logic [2:0] p0_sync_r;
	logic [2:0] p1_sync_r;
	logic p0_lvl_r;
	logic p1_lvl_r;
	logic p0_lvl_nxt;
	logic p1_lvl_nxt;
	assign p0_lvl_nxt = (p0_sync_r[1] == p0_sync_r[2]) ? p0_sync_r[2] : p0_lvl_r;
	assign p1_lvl_nxt = (p1_sync_r[1] == p1_sync_r[2]) ? p1_sync_r[2] : p1_lvl_r;
	always_ff @(posedge mclk) begin
		if (rst) begin
			p0_sync_r <= 3'h0;
			p1_sync_r <= 3'h0;
			p0_lvl_r <= 1'b0;
			p1_lvl_r <= 1'b0;
		end else begin
			p0_sync_r <= {p0_sync_r[1:0], gp_pin_zero_in};
			p1_sync_r <= {p1_sync_r[1:0], gp_pin_one_in};
			p0_lvl_r <= p0_lvl_nxt;
			p1_lvl_r <= p1_lvl_nxt;
		end
	end

	// ----------------------------------------
	// Strobe edge detection
	// ----------------------------------------
	logic iow_d_r;
	logic ior_d_r;
	logic wr_start;
	logic rd_active;
	always_ff @(posedge mclk) begin
		if (rst) begin
			iow_d_r <= 1'b1;
			ior_d_r <= 1'b1;
		end else begin
			iow_d_r <= iow_n;
			ior_d_r <= ior_n;
		end
	end
	assign wr_start = iow_d_r && !iow_n && !aen_n;
	assign rd_active = !ior_n && !aen_n;

	// ----------------------------------------
	// Extended mode unlock
	// ----------------------------------------
	igpd_cfg_e cfg_st_r;
	igpd_cfg_e cfg_st_nxt;
	logic [7:0] keysel_r;
	logic kas_r;
	logic [10:0] base_addr;
	logic [7:0] key_val;
	logic hit_index;
	logic hit_data;
	logic key_wr;
	logic exit_wr;
	assign base_addr = kas_r ? IGPD_PORT_3F0 : IGPD_PORT_250;
	// key chosen by two select bits
	assign key_val = kas_r ? (keysel_r[IGPD_KEY_VALUE_SEL_BIT] ? IGPD_KEY_87 : IGPD_KEY_86) :
		(keysel_r[IGPD_KEY_VALUE_SEL_BIT] ? IGPD_KEY_89 : IGPD_KEY_88);
	assign hit_index = (sa == base_addr);
	assign hit_data = (sa == base_addr + 11'h001);
	assign key_wr = wr_start && hit_index && (sd_in == key_val);
	assign exit_wr = wr_start && hit_index && (sd_in == IGPD_EXIT_KEY);

	always_comb begin
		cfg_st_nxt = cfg_st_r;
		case (cfg_st_r)
			IGPD_LOCKED: begin
				if (key_wr) begin
					cfg_st_nxt = kas_r ? IGPD_HALF : IGPD_OPEN;
				end
			end
			IGPD_HALF: begin
				if (key_wr) begin
					cfg_st_nxt = IGPD_OPEN;
				end else if (wr_start) begin
					cfg_st_nxt = IGPD_LOCKED;
				end
			end
			IGPD_OPEN: begin
				if (exit_wr) begin
					cfg_st_nxt = IGPD_LOCKED;
				end
			end
			default: begin
				cfg_st_nxt = IGPD_LOCKED;
			end
		endcase
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic ext_mode;
	logic [7:0] index_r;
	logic [7:0] p0_lo_r;
	logic [7:0] p0_hi_r;
	logic [7:0] p1_lo_r;
	logic [7:0] p1_hi_r;
	logic [7:0] p0_fn_r;
	logic [7:0] p1_fn_r;
	logic idx_wr;
	logic dat_wr;
	assign ext_mode = (cfg_st_r == IGPD_OPEN);
	// index then data, only when unlocked
	assign idx_wr = ext_mode && wr_start && hit_index && (sd_in != IGPD_EXIT_KEY);
	assign dat_wr = ext_mode && wr_start && hit_data;

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_st_r <= IGPD_LOCKED;
			kas_r <= IGPD_RST_KEY_ADDR_SEL;
		end else begin
			cfg_st_r <= cfg_st_nxt;
			kas_r <= key_addr_sel;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			index_r <= IGPD_RST_ZERO;
			keysel_r <= IGPD_RST_KEYSEL;
			p0_lo_r <= IGPD_RST_ZERO;
			p0_hi_r <= IGPD_RST_ZERO;
			p1_lo_r <= IGPD_RST_ZERO;
			p1_hi_r <= IGPD_RST_ZERO;
			p0_fn_r <= IGPD_RST_ZERO;
			p1_fn_r <= IGPD_RST_ZERO;
		end else begin
			if (idx_wr) begin
				index_r <= sd_in;
			end
			if (dat_wr) begin
				if (index_r == IGPD_IDX_KEYSEL) begin
					keysel_r <= sd_in;
				end else if (index_r == IGPD_IDX_P0_LO) begin
					p0_lo_r <= sd_in;
				end else if (index_r == IGPD_IDX_P0_HI) begin
					p0_hi_r <= sd_in & 8'hC7;
				end else if (index_r == IGPD_IDX_P1_LO) begin
					p1_lo_r <= sd_in;
				end else if (index_r == IGPD_IDX_P1_HI) begin
					p1_hi_r <= sd_in & 8'hC7;
				end else if (index_r == IGPD_IDX_P0_FN) begin
					p0_fn_r <= sd_in;
				end else if (index_r == IGPD_IDX_P1_FN) begin
					p1_fn_r <= sd_in;
				end
			end
		end
	end

	// ----------------------------------------
	// Read-back mux
	// ----------------------------------------
	logic [7:0] cfg_rd;
	assign cfg_rd = (index_r == IGPD_IDX_KEYSEL) ? keysel_r :
		(index_r == IGPD_IDX_P0_LO) ? p0_lo_r :
		(index_r == IGPD_IDX_P0_HI) ? p0_hi_r :
		(index_r == IGPD_IDX_P1_LO) ? p1_lo_r :
		(index_r == IGPD_IDX_P1_HI) ? p1_hi_r :
		(index_r == IGPD_IDX_P0_FN) ? p0_fn_r :
		(index_r == IGPD_IDX_P1_FN) ? p1_fn_r : 8'h00;

	// ----------------------------------------
	// Pin instances
	// ----------------------------------------
	logic p0_rd_hit;
	logic p0_rd_bit;
	logic p1_rd_hit;
	logic p1_rd_bit;
	igpd_pin u_pin0 (
		.mclk(mclk),
		.rst(rst),
		.sa(sa),
		.aen_n(aen_n),
		.iow_n(iow_n),
		.ior_n(ior_n),
		.sd_in(sd_in[0]),
		.match_addr({p0_hi_r[IGPD_ADDR_HI_MSB:0], p0_lo_r}),
		.cmp_mask(p0_hi_r[IGPD_MASK_MSB:IGPD_MASK_LSB]),
		.func_ctrl(p0_fn_r),
		.pin_in(p0_lvl_r),
		.pin_out(gp_pin_zero_out),
		.pin_oe(gp_pin_zero_oe),
		.rd_hit(p0_rd_hit),
		.rd_bit(p0_rd_bit)
	);
	igpd_pin u_pin1 (
		.mclk(mclk),
		.rst(rst),
		.sa(sa),
		.aen_n(aen_n),
		.iow_n(iow_n),
		.ior_n(ior_n),
		.sd_in(sd_in[0]),
		.match_addr({p1_hi_r[IGPD_ADDR_HI_MSB:0], p1_lo_r}),
		.cmp_mask(p1_hi_r[IGPD_MASK_MSB:IGPD_MASK_LSB]),
		.func_ctrl(p1_fn_r),
		.pin_in(p1_lvl_r),
		.pin_out(gp_pin_one_out),
		.pin_oe(gp_pin_one_oe),
		.rd_hit(p1_rd_hit),
		.rd_bit(p1_rd_bit)
	);

	// ----------------------------------------
	// Data bus drive
	// ----------------------------------------
	logic cfg_rd_hit;
	logic [7:0] sd_nxt;
	logic [7:0] sd_r;
	assign cfg_rd_hit = ext_mode && rd_active && (hit_data || hit_index);
	// pin bit on data line 0
	assign sd_nxt = cfg_rd_hit ? (hit_data ? cfg_rd : index_r) :
		{7'h00, (p0_rd_hit && p0_rd_bit) || (p1_rd_hit && p1_rd_bit)};
	always_ff @(posedge mclk) begin
		if (rst) begin
			sd_r <= 8'h00;
		end else begin
			sd_r <= sd_nxt;
		end
	end
	assign sd_out = sd_r;
	assign sd_oe = cfg_rd_hit || p0_rd_hit || p1_rd_hit;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// locked blocks data writes
	chk_locked_no_write: assert property (@(posedge mclk) disable iff (rst)
		(!ext_mode && wr_start && hit_data) |=> $stable(p0_fn_r) && $stable(p1_fn_r))
		else $error("write while locked");
	chk_keysel_reset: assert property (@(posedge mclk) $fell(rst) |-> keysel_r == IGPD_RST_KEYSEL)
		else $error("key select reset wrong");
	chk_p0_lo_write: assert property (@(posedge mclk) disable iff (rst)
		(dat_wr && index_r == IGPD_IDX_P0_LO) |=> p0_lo_r == $past(sd_in)) else $error("addr low not written");
	chk_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
		p0_hi_r[5:3] == 3'h0 && p1_hi_r[5:3] == 3'h0) else $error("reserved bits set");
	// input bit reaches bus next cycle
	chk_input_path: assert property (@(posedge mclk) disable iff (rst)
		(p0_rd_hit && !p1_rd_hit && !cfg_rd_hit) |=> sd_out[0] == $past(p0_rd_bit)) else $error("input bit lost");
	// key writes while locked or half open
	sequence seq_key_locked;
		cfg_st_r == IGPD_LOCKED && key_wr;
	endsequence
	sequence seq_key_half;
		cfg_st_r == IGPD_HALF && key_wr;
	endsequence
	// one key opens at 250H, half opens at 3F0H
	chk_key_first: assert property (@(posedge mclk) disable iff (rst)
		seq_key_locked |=> cfg_st_r == ($past(kas_r) ? IGPD_HALF : IGPD_OPEN)) else $error("first key not taken");
	chk_key_second: assert property (@(posedge mclk) disable iff (rst)
		seq_key_half |=> ext_mode) else $error("second key not taken");
	chk_exit_locks: assert property (@(posedge mclk) disable iff (rst)
		(ext_mode && exit_wr) |=> !ext_mode) else $error("exit key ignored");
endmodule : igpd_top
`default_nettype wire

// ### rtl/igpd_pkg.sv
// Package: constants for the ISA general-purpose pin decoder
package igpd_pkg;
	// ----------------------------------------
	// Configuration port addresses and keys
	// ----------------------------------------
	localparam logic [10:0] IGPD_PORT_250 = 11'h250;
	localparam logic [10:0] IGPD_PORT_3F0 = 11'h3F0;
	localparam logic [7:0] IGPD_KEY_88 = 8'h88;
	localparam logic [7:0] IGPD_KEY_89 = 8'h89;
	localparam logic [7:0] IGPD_KEY_86 = 8'h86;
	localparam logic [7:0] IGPD_KEY_87 = 8'h87;
	localparam logic [7:0] IGPD_EXIT_KEY = 8'hAA;
	// ----------------------------------------
	// Register indexes
	// ----------------------------------------
	localparam logic [7:0] IGPD_IDX_KEYSEL = 8'h0C;
	localparam logic [7:0] IGPD_IDX_P0_LO = 8'h10;
	localparam logic [7:0] IGPD_IDX_P0_HI = 8'h11;
	localparam logic [7:0] IGPD_IDX_P1_LO = 8'h12;
	localparam logic [7:0] IGPD_IDX_P1_HI = 8'h13;
	localparam logic [7:0] IGPD_IDX_P0_FN = 8'h14;
	localparam logic [7:0] IGPD_IDX_P1_FN = 8'h15;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] IGPD_RST_KEYSEL = 8'h28;
	localparam logic [7:0] IGPD_RST_ZERO = 8'h00;
	localparam logic IGPD_RST_KEY_ADDR_SEL = 1'b0;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int IGPD_KEY_VALUE_SEL_BIT = 5;
	localparam int IGPD_MASK_MSB = 7;
	localparam int IGPD_MASK_LSB = 6;
	localparam int IGPD_ADDR_HI_MSB = 2;
	localparam int IGPD_FN_MSB = 7;
	localparam int IGPD_FN_LSB = 5;
	localparam int IGPD_POL_BIT = 4;
	localparam int IGPD_RDQ_BIT = 3;
	localparam int IGPD_WRQ_BIT = 2;
	localparam int IGPD_OINV_BIT = 1;
	localparam int IGPD_IINV_BIT = 0;
	// ----------------------------------------
	// Pin function codes
	// ----------------------------------------
	localparam logic [2:0] IGPD_FN_OFF = 3'h0;
	localparam logic [2:0] IGPD_FN_OUT = 3'h1;
	localparam logic [2:0] IGPD_FN_IN = 3'h2;
	localparam logic [2:0] IGPD_FN_BIDIR = 3'h3;
	typedef enum logic [1:0] {IGPD_LOCKED, IGPD_HALF, IGPD_OPEN} igpd_cfg_e;
endpackage : igpd_pkg

// ### rtl/igpd_pin.sv
// One general-purpose pin: address compare, data and chip-select paths
`timescale 1ns/1ps
`default_nettype none
module igpd_pin
	import igpd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [10:0] sa,
	input wire logic aen_n,
	input wire logic iow_n,
	input wire logic ior_n,
	input wire logic sd_in,
	input wire logic [10:0] match_addr,
	input wire logic [1:0] cmp_mask,
	input wire logic [7:0] func_ctrl,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic rd_hit,
	output logic rd_bit
);
	logic [10:0] care;
	logic match;
	logic [2:0] func_sel;
	logic is_cs;
	logic wr_hit;
	logic cs_act;
	logic data_r;
	logic data_nxt;
	logic [2:0] func_last_r;

	// ----------------------------------------
	// Address compare
	// ----------------------------------------
	// low bits ignored
	assign care = (cmp_mask == 2'b00) ? 11'h7FF : (cmp_mask == 2'b01) ? 11'h7FE :
		(cmp_mask == 2'b10) ? 11'h7FC : 11'h7F8;
	assign match = !aen_n && (((sa ^ match_addr) & care) == 11'h000);
	assign func_sel = func_ctrl[IGPD_FN_MSB:IGPD_FN_LSB];
	assign is_cs = func_sel[2];
	assign wr_hit = match && !iow_n && (func_sel == IGPD_FN_OUT || func_sel == IGPD_FN_BIDIR);
	// pin level to data line 0
	assign rd_hit = match && !ior_n && (func_sel == IGPD_FN_IN || func_sel == IGPD_FN_BIDIR);
	assign rd_bit = pin_in ^ func_ctrl[IGPD_IINV_BIT];

	// ----------------------------------------
	// Chip select
	// ----------------------------------------
	// strobe qualification
	assign cs_act = match && (func_ctrl[IGPD_RDQ_BIT:IGPD_WRQ_BIT] == 2'b00 ? 1'b1 :
		func_ctrl[IGPD_RDQ_BIT:IGPD_WRQ_BIT] == 2'b01 ? !iow_n :
		func_ctrl[IGPD_RDQ_BIT:IGPD_WRQ_BIT] == 2'b10 ? !ior_n : (!iow_n || !ior_n));

	// ----------------------------------------
	// Output latch
	// ----------------------------------------
	// bit held until next write or mode change
	assign data_nxt = wr_hit ? (sd_in ^ func_ctrl[IGPD_OINV_BIT]) :
		(func_sel != func_last_r) ? 1'b0 : data_r;
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_r <= 1'b0;
			func_last_r <= IGPD_FN_OFF;
		end else begin
			data_r <= data_nxt;
			func_last_r <= func_sel;
		end
	end

	// tri-state when off; polarity for select
	assign pin_oe = (func_sel == IGPD_FN_OUT) || (func_sel == IGPD_FN_BIDIR) || is_cs;
	assign pin_out = is_cs ? (cs_act ~^ func_ctrl[IGPD_POL_BIT]) : data_r;

	chk_off_tristate: assert property (@(posedge mclk) disable iff (rst)
		(func_sel == IGPD_FN_OFF) |-> !pin_oe) else $error("pin driven while off");
	chk_write_capture: assert property (@(posedge mclk) disable iff (rst)
		(wr_hit && func_sel == $past(func_sel)) |=> data_r == $past(sd_in ^ func_ctrl[IGPD_OINV_BIT]))
		else $error("write bit not captured");
	chk_cs_polarity: assert property (@(posedge mclk) disable iff (rst)
		(is_cs && !match) |-> pin_out == !func_ctrl[IGPD_POL_BIT]) else $error("select idle level wrong");
	chk_cs_active: assert property (@(posedge mclk) disable iff (rst)
		(is_cs && match && func_ctrl[IGPD_RDQ_BIT:IGPD_WRQ_BIT] == 2'b00) |-> pin_out == func_ctrl[IGPD_POL_BIT])
		else $error("select not asserted");
	chk_hold_data: assert property (@(posedge mclk) disable iff (rst)
		(!wr_hit && func_sel == func_last_r && !is_cs) |=> $stable(data_r)) else $error("bit not held");
endmodule : igpd_pin
`default_nettype wire

// ### bench/igpd_board.sv
// Board-side model of one general-purpose pin wire
`timescale 1ns/1ps
`default_nettype none
module igpd_board (
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic ext_drv,
	input wire logic ext_lvl,
	output logic pin_wire
);
	// device drive wins, else board, else pull-up
	assign pin_wire = pin_oe ? pin_out : (ext_drv ? ext_lvl : 1'b1);
endmodule : igpd_board
`default_nettype wire

// ### bench/isa_gp_pin_address_decoder_test.sv
// Self-checking bench for the ISA general-purpose pin decoder
`timescale 1ns/1ps
`default_nettype none
module isa_gp_pin_address_decoder_test;
	import igpd_pkg::*;
	typedef struct {int kind; logic [7:0] v;} igpd_exp_s;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic aen_n = 1'b1;
	logic iow_n = 1'b1;
	logic ior_n = 1'b1;
	logic kas = 1'b0;
	logic ext_lvl = 1'b0;
	logic [10:0] sa = 11'h000;
	logic [10:0] base = IGPD_PORT_250;
	logic [7:0] sd_in = 8'h00;
	logic [7:0] sd_out;
	logic sd_oe, p0_out, p0_oe, p0_wire, p1_out, p1_oe, p1_wire, act;
	logic [31:0] rnd;
	igpd_exp_s exp_q[$];
	igpd_exp_s e;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #10 mclk = ~mclk;
	igpd_top dut (.mclk(mclk), .rst(rst), .sa(sa), .aen_n(aen_n), .iow_n(iow_n), .ior_n(ior_n),
		.sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .key_addr_sel(kas), .gp_pin_zero_in(p0_wire),
		.gp_pin_zero_out(p0_out), .gp_pin_zero_oe(p0_oe), .gp_pin_one_in(p1_wire),
		.gp_pin_one_out(p1_out), .gp_pin_one_oe(p1_oe));
	igpd_board board0 (.pin_out(p0_out), .pin_oe(p0_oe), .ext_drv(1'b1), .ext_lvl(ext_lvl),
		.pin_wire(p0_wire));
	igpd_board board1 (.pin_out(p1_out), .pin_oe(p1_oe), .ext_drv(1'b0), .ext_lvl(1'b0),
		.pin_wire(p1_wire));
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, want, seen);
		end
	endtask : check
	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge mclk) begin
		#5;
		while (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			case (e.kind)
				0: check("sd_out", sd_out, e.v);
				1: check("sd_oe", {7'h00, sd_oe}, e.v);
				2: check("pin0", {6'h00, p0_oe, p0_out}, e.v);
				3: check("pin1", {6'h00, p1_oe, p1_out}, e.v);
				4: check("sd0", {7'h00, sd_out[0]}, e.v);
				default: check("pin0_oe", {7'h00, p0_oe}, e.v);
			endcase
		end
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			test_done();
		end
	end
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic io_cyc(input logic [10:0] a, input logic [7:0] d, input logic wr, input logic rd,
		input int kind, input logic [7:0] v, input int n);
		@(negedge mclk);
		sa = a;
		sd_in = d;
		aen_n = 1'b0;
		iow_n = ~wr;
		ior_n = ~rd;
		if (kind >= 0)
			exp_q.push_back('{kind, v});
		repeat (n) @(negedge mclk);
		iow_n = 1'b1;
		ior_n = 1'b1;
		aen_n = 1'b1;
		sa = ~a;
	endtask : io_cyc
	task automatic io_wr(input logic [10:0] a, input logic [7:0] d);
		io_cyc(a, d, 1'b1, 1'b0, -1, 8'h00, 1);
	endtask : io_wr
	task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
		io_wr(base, idx);
		io_wr(base + 11'h1, d);
	endtask : cfg_wr
	task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] v);
		io_wr(base, idx);
		io_cyc(base + 11'h1, 8'h00, 1'b0, 1'b1, 0, v, 2);
	endtask : cfg_rd
	task automatic rekey(input logic k, input logic [7:0] key, input int times);
		io_wr(base, IGPD_EXIT_KEY);
		kas = k;
		base = k ? IGPD_PORT_3F0 : IGPD_PORT_250;
		repeat (3) @(negedge mclk);
		repeat (times) io_wr(base, key);
	endtask : rekey
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rnd = $urandom(32'h81B2CCF5);
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		io_cyc(11'h251, 8'h00, 1'b0, 1'b1, 1, 8'h00, 2);
		io_cyc(11'h000, 8'h00, 1'b0, 1'b0, 5, 8'h00, 1);
		io_wr(IGPD_PORT_250, IGPD_KEY_89);
		cfg_rd(IGPD_IDX_KEYSEL, IGPD_RST_KEYSEL);
		for (int i = 16; i < 22; i++) cfg_rd(i[7:0], IGPD_RST_ZERO);
		cfg_rd(8'h20, 8'h00);
		rnd = $urandom();
		cfg_wr(IGPD_IDX_P0_LO, rnd[7:0]);
		cfg_rd(IGPD_IDX_P0_LO, rnd[7:0]);
		cfg_wr(IGPD_IDX_P1_LO, rnd[15:8]);
		cfg_rd(IGPD_IDX_P1_LO, rnd[15:8]);
		cfg_wr(IGPD_IDX_P0_HI, {rnd[17:16], 3'h0, rnd[20:18]});
		cfg_rd(IGPD_IDX_P0_HI, {rnd[17:16], 3'h0, rnd[20:18]});
		cfg_wr(IGPD_IDX_P0_LO, 8'h00);
		cfg_wr(IGPD_IDX_P0_FN, 8'h20);
		for (int m = 0; m < 4; m++) begin
			cfg_wr(IGPD_IDX_P0_HI, {m[1:0], 6'h03});
			io_cyc(11'h300 | ((11'h1 << m) - 11'h1), 8'h01, 1'b1, 1'b0, 2, 8'h03, 1);
			io_cyc(11'h300 | (11'h1 << m), 8'h00, 1'b1, 1'b0, 2, 8'h03, 1);
			io_cyc(11'h300, 8'hFE, 1'b1, 1'b0, 2, 8'h02, 1);
		end
		cfg_wr(IGPD_IDX_P0_FN, 8'h22);
		io_cyc(11'h300, 8'h01, 1'b1, 1'b0, 2, 8'h02, 1);
		cfg_wr(IGPD_IDX_P0_FN, 8'h00);
		io_cyc(11'h300, 8'h01, 1'b1, 1'b0, 5, 8'h00, 1);
		cfg_wr(IGPD_IDX_P0_FN, 8'h40);
		ext_lvl = 1'b1;
		repeat (6) @(negedge mclk);
		io_cyc(11'h300, 8'h00, 1'b0, 1'b1, 4, 8'h01, 2);
		cfg_wr(IGPD_IDX_P0_FN, 8'h41);
		io_cyc(11'h300, 8'h00, 1'b0, 1'b1, 4, 8'h00, 2);
		ext_lvl = 1'b0;
		cfg_wr(IGPD_IDX_P0_FN, 8'h60);
		io_cyc(11'h300, 8'h01, 1'b1, 1'b0, 2, 8'h03, 1);
		repeat (6) @(negedge mclk);
		io_cyc(11'h300, 8'h00, 1'b0, 1'b1, 4, 8'h01, 2);
		for (int c = 0; c < 8; c++) begin
			cfg_wr(IGPD_IDX_P0_FN, {3'h4, c[2:0], 2'h0});
			for (int s = 0; s < 3; s++) begin
				act = (c[1:0] == 2'h0) || (c[0] && s == 1) || (c[1] && s == 2);
				io_cyc(11'h300, 8'h00, s == 1, s == 2, 2, {7'h01, ~(act ^ c[2])}, 1);
			end
			io_cyc(11'h310, 8'h00, 1'b1, 1'b1, 2, {7'h01, ~c[2]}, 1);
		end
		cfg_wr(IGPD_IDX_P1_LO, 8'hA0);
		cfg_wr(IGPD_IDX_P1_HI, 8'hC2);
		cfg_wr(IGPD_IDX_P1_FN, 8'h20);
		io_cyc(11'h2A7, 8'h01, 1'b1, 1'b0, 3, 8'h03, 1);
		io_cyc(11'h2A8, 8'h00, 1'b1, 1'b0, 3, 8'h03, 1);
		rekey(1'b1, IGPD_KEY_87, 1);
		io_cyc(base + 11'h1, 8'h00, 1'b0, 1'b1, 1, 8'h00, 2);
		io_wr(base, IGPD_KEY_87);
		cfg_rd(IGPD_IDX_KEYSEL, IGPD_RST_KEYSEL);
		cfg_wr(IGPD_IDX_KEYSEL, 8'h08);
		rekey(1'b1, IGPD_KEY_86, 2);
		cfg_rd(IGPD_IDX_KEYSEL, 8'h08);
		rekey(1'b0, IGPD_KEY_88, 1);
		cfg_rd(IGPD_IDX_KEYSEL, 8'h08);
		repeat (3) @(negedge mclk);
		test_done();
	end
endmodule : isa_gp_pin_address_decoder_test
`default_nettype wire
